// ### sscr_regs.sv
/*
 Soft strap register bank with AXI4-Lite slave, latch sequencer and steering logic.
 Assumes one clock clk_sys, async active-low rstn, receive and link events from the same clock.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sscr_consts.svh"
module sscr_regs
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sym_j_seen,
   input  wire logic        sym_k_seen,
   input  wire logic        sym_false_start,
   input  wire logic        partner_forced_100,
   input  wire logic        std_full_duplex,
   output var  logic        rx_valid,
   output var  logic        rx_error,
   output var  logic        link_full_duplex,
   output var  logic        fast_pd_link_up,
   output var  logic        early_rx_valid_enable,
   output var  logic        irq_or_powerdown_oe,
   output var  logic        internal_reset,
   output var  logic [15:0] phy_special_control
);
   logic [15:0] first_ff, nxt_first;
   logic [15:0] second_ff, nxt_second;
   sscr_pkg::sscr_cfg_t cfg_ff, nxt_cfg;
   sscr_pkg::sscr_state_t st_ff, nxt_st;
   logic [3:0]  cnt_ff, nxt_cnt;
   logic [11:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0]  wstrb_ff, nxt_wstrb;
   logic        aw_ff, nxt_aw, w_ff, nxt_w;
   logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        rxv_ff, nxt_rxv, rxe_ff, nxt_rxe, fd_ff, nxt_fd, jpend_ff, nxt_jpend;
   logic        done_wr;

   // Bus slave: address and data captured independently, response after both
   always_comb
   begin
      nxt_aw = aw_ff;
      nxt_w = w_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      nxt_first = first_ff;
      nxt_second = second_ff;
      done_wr = 1'b0;
      // Capture on the registered readies so a valid held through reset is not taken unseen
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_aw = 1'b1;
         nxt_awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_w = 1'b1;
         nxt_wdata = s_axi_wdata;
         nxt_wstrb = s_axi_wstrb;
      end
      if (aw_ff && w_ff)
      begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = `SSCR_RESP_OKAY;
         if (awaddr_ff[11:2] == `SSCR_ADDR_FIRST >> 2)
         begin
            if (wstrb_ff[0])
               nxt_first[7:0] = wdata_ff[7:0];
            if (wstrb_ff[1])
               nxt_first[15:8] = wdata_ff[15:8];
            done_wr = wstrb_ff[1] && wdata_ff[`SSCR_BIT_DONE];
         end
         else if (awaddr_ff[11:2] == `SSCR_ADDR_SECOND >> 2)
         begin
            if (wstrb_ff[0])
               nxt_second[7:0] = wdata_ff[7:0];
            if (wstrb_ff[1])
               nxt_second[15:8] = wdata_ff[15:8];
            nxt_second = nxt_second & `SSCR_SECOND_WMASK;
         end
         else if (awaddr_ff[11:2] != `SSCR_ADDR_STATUS >> 2)
            nxt_bresp = `SSCR_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready)
         nxt_bvalid = 1'b0;
      if (nxt_first[`SSCR_BIT_RMDIX] || nxt_first[`SSCR_BIT_FMDIX])
         nxt_second[`SSCR_BIT_FAST_PD] = 1'b1;
      // A completion written on the latch cycle wins over the self-clear
      if (st_ff == sscr_pkg::SSCR_LATCH && !done_wr)
         nxt_first[`SSCR_BIT_DONE] = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `SSCR_RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         if (s_axi_araddr[11:2] == `SSCR_ADDR_FIRST >> 2)
            nxt_rdata = {16'h0000, first_ff};
         else if (s_axi_araddr[11:2] == `SSCR_ADDR_SECOND >> 2)
            nxt_rdata = {16'h0000, second_ff};
         else if (s_axi_araddr[11:2] == `SSCR_ADDR_STATUS >> 2)
            nxt_rdata = {24'h00_0000, 2'b00, st_ff, cfg_ff};
         else
            nxt_rresp = `SSCR_RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
         nxt_rvalid = 1'b0;
   end

   // Latch sequencer: pulse first, then capture, so new values latch one cycle after the core leaves reset
   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_cfg = cfg_ff;
      case (st_ff)
         sscr_pkg::SSCR_IDLE:
         begin
            if (done_wr)
            begin
               nxt_st = sscr_pkg::SSCR_PULSE;
               nxt_cnt = `SSCR_RST_PULSE_CYC;
            end
         end
         sscr_pkg::SSCR_PULSE:
         begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1)
               nxt_st = sscr_pkg::SSCR_LATCH;
         end
         sscr_pkg::SSCR_LATCH:
         begin
            nxt_cfg.early_rx_valid_enable = first_ff[`SSCR_BIT_EARLY_RXDV];
            nxt_cfg.irq_output_enable = first_ff[`SSCR_BIT_IRQ_OE];
            nxt_cfg.fast_pd_link_up = second_ff[`SSCR_BIT_FAST_PD];
            nxt_cfg.forced_partner_full_duplex = second_ff[`SSCR_BIT_EXT_FD];
            nxt_st = sscr_pkg::SSCR_IDLE;
            if (done_wr)
            begin
               nxt_st = sscr_pkg::SSCR_PULSE;
               nxt_cnt = `SSCR_RST_PULSE_CYC;
            end
         end
         default:
            nxt_st = sscr_pkg::SSCR_IDLE;
      endcase
   end

   // Receive and duplex steering use only latched copies
   always_comb
   begin
      nxt_rxv = rxv_ff;
      nxt_rxe = 1'b0;
      nxt_jpend = jpend_ff;
      if (st_ff != sscr_pkg::SSCR_IDLE)
      begin
         nxt_rxv = 1'b0;
         nxt_jpend = 1'b0;
      end
      else if (cfg_ff.early_rx_valid_enable)
      begin
         if (sym_j_seen)
            nxt_rxv = 1'b1;
         if (sym_false_start)
         begin
            nxt_rxv = 1'b0;
            nxt_rxe = 1'b1;
         end
      end
      else
      begin
         if (sym_j_seen)
            nxt_jpend = 1'b1;
         if (jpend_ff && sym_k_seen)
         begin
            nxt_rxv = 1'b1;
            nxt_jpend = 1'b0;
         end
         if (sym_false_start)
         begin
            nxt_rxv = 1'b0;
            nxt_jpend = 1'b0;
         end
      end
      if (cfg_ff.forced_partner_full_duplex && partner_forced_100)
         nxt_fd = 1'b1;
      else
         nxt_fd = std_full_duplex;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         first_ff <= `SSCR_FIRST_RST;
         second_ff <= `SSCR_SECOND_RST;
         cfg_ff <= '0;
         st_ff <= sscr_pkg::SSCR_IDLE;
         cnt_ff <= 4'h0;
         awaddr_ff <= 12'h000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'b00;
         rvalid_ff <= 1'b0;
         rresp_ff <= 2'b00;
         rdata_ff <= 32'h0000_0000;
         rxv_ff <= 1'b0;
         rxe_ff <= 1'b0;
         fd_ff <= 1'b0;
         jpend_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         first_ff <= nxt_first;
         second_ff <= nxt_second;
         cfg_ff <= nxt_cfg;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         rxv_ff <= nxt_rxv;
         rxe_ff <= nxt_rxe;
         fd_ff <= nxt_fd;
         jpend_ff <= nxt_jpend;
      end
   end

   // Ready is high while the holding slot is free and no response is pending; all are flop outputs
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         internal_reset <= 1'b0;
         phy_special_control <= 16'h0000;
      end
      else if (clk_en)
      begin
         s_axi_awready <= !nxt_aw && !nxt_bvalid;
         s_axi_wready <= !nxt_w && !nxt_bvalid;
         s_axi_arready <= !nxt_rvalid;
         internal_reset <= (nxt_st == sscr_pkg::SSCR_PULSE);
         phy_special_control <= {15'h0000, nxt_cfg.irq_output_enable};
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign rx_valid = rxv_ff;
   assign rx_error = rxe_ff;
   assign link_full_duplex = fd_ff;
   assign fast_pd_link_up = cfg_ff.fast_pd_link_up;
   assign early_rx_valid_enable = cfg_ff.early_rx_valid_enable;
   assign irq_or_powerdown_oe = cfg_ff.irq_output_enable;
endmodule
`default_nettype wire

// ### sscr_consts.svh
/*
 Offsets, field positions, reset values and timing counts for the soft strap registers.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SSCR_CONSTS_SVH
`define SSCR_CONSTS_SVH
`define SSCR_IDX_FIRST        8'h09
`define SSCR_IDX_SECOND       8'h0A
`define SSCR_ADDR_FIRST       12'h024
`define SSCR_ADDR_SECOND      12'h028
`define SSCR_ADDR_STATUS      12'h040
`define SSCR_BIT_DONE         15
`define SSCR_BIT_RMDIX        6
`define SSCR_BIT_FMDIX        5
`define SSCR_BIT_EARLY_RXDV   1
`define SSCR_BIT_IRQ_OE       0
`define SSCR_BIT_FAST_PD      6
`define SSCR_BIT_EXT_FD       5
`define SSCR_FIRST_RST        16'h0000
`define SSCR_SECOND_RST       16'h0000
`define SSCR_SECOND_WMASK     16'h3FFF
`define SSCR_RST_PULSE_CYC    4'h4
`define SSCR_RESP_OKAY        2'b00
`define SSCR_RESP_SLVERR      2'b10
`endif

// ### sscr_pkg.sv
/*
 Types shared by the soft strap register bank.
 Assumes sscr_consts.svh is on the include path.
*/
`include "sscr_consts.svh"
package sscr_pkg;
   typedef enum logic [1:0] {
      SSCR_IDLE = 2'b00,
      SSCR_PULSE = 2'b01,
      SSCR_LATCH = 2'b10
   } sscr_state_t;
   typedef struct packed {
      logic early_rx_valid_enable;
      logic irq_output_enable;
      logic fast_pd_link_up;
      logic forced_partner_full_duplex;
   } sscr_cfg_t;
endpackage

// ### sscr_regs_properties.sv
/*
 Port checker for the soft strap register bank.
 Assumes the sscr_regs port names; bound to every instance below.
*/
`timescale 1ns/1ns
`default_nettype none
module sscr_regs_properties
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        sym_k_seen,
   input wire logic        sym_false_start,
   input wire logic        partner_forced_100,
   input wire logic        std_full_duplex,
   input wire logic        rx_valid,
   input wire logic        rx_error,
   input wire logic        link_full_duplex,
   input wire logic        early_rx_valid_enable,
   input wire logic        fast_pd_link_up,
   input wire logic        irq_or_powerdown_oe,
   input wire logic        internal_reset,
   input wire logic [15:0] phy_special_control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_pulse_len: assert property
      ($rose(internal_reset) |-> internal_reset[*4] ##1 !internal_reset)
      else $error("Internal reset pulse length wrong");
   a_irq_copy: assert property
      ($fell(internal_reset) |-> ##[1:3] (phy_special_control == {15'h0000, irq_or_powerdown_oe}))
      else $error("Control bit 0 differs from pin mode");
   a_cfg_frozen: assert property
      ($changed({early_rx_valid_enable, irq_or_powerdown_oe, fast_pd_link_up}) |->
       $past(internal_reset) || $past(internal_reset, 2) || $past(internal_reset, 3))
      else $error("Latched config moved outside reset");
   a_early_err: assert property
      (sym_false_start && early_rx_valid_enable |=> rx_error)
      else $error("False start gave no receive error");
   a_err_cause: assert property
      (rx_error |-> $past(sym_false_start))
      else $error("Receive error without false start");
   a_normal_dv: assert property
      (!early_rx_valid_enable && $rose(rx_valid) |-> $past(sym_k_seen))
      else $error("Receive valid before start pair");
   a_std_duplex: assert property
      (!partner_forced_100 |=> link_full_duplex == $past(std_full_duplex))
      else $error("Duplex not from standard resolution");
   a_read_answer: assert property
      (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late");
   a_read_hold: assert property
      (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped before taken");
endmodule
bind sscr_regs sscr_regs_properties i_props (.*);
`default_nettype wire

// ### sscr_regs_tb_top.sv
/*
 Self-checking bench for the soft strap register bank.
 Assumes sscr_consts.svh on the include path and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sscr_consts.svh"
module sscr_regs_tb_top;
   logic        clk_sys = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        sym_j_seen = 1'b0, sym_k_seen = 1'b0, sym_false_start = 1'b0;
   logic        partner_forced_100 = 1'b0, std_full_duplex = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        rx_valid, rx_error, link_full_duplex, early_rx_valid_enable;
   logic        irq_or_powerdown_oe, internal_reset, fast_pd_link_up;
   logic [15:0] phy_special_control;
   int          n_mismatch = 0, check_count = 0, cyc = 0;
   sscr_regs i_dut (.*, .clk_en(1'b1), .s_axi_wstrb(4'hf));
   always #2 clk_sys = ~clk_sys;
   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_mismatch++;
         end_of_test;
      end
   end
   task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
      check_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Address and data may be taken at different edges
      forever
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 34'(s_axi_bresp), 34'(er));
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er,
                     input int lag = 0);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      // A late rready makes the slave hold its answer
      s_axi_rready <= (lag == 0);
      forever
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid)
         begin
            lag--;
            if (lag == 0) s_axi_rready <= 1'b1;
         end
      end
      s_axi_rready <= 1'b0;
      chk("read", {s_axi_rresp, s_axi_rdata}, {er, 16'h0000, e});
   endtask
   // One-cycle symbol pulse {j,k,false}; outputs settled on return
   task automatic pls(input logic [2:0] m);
      @(posedge clk_sys);
      {sym_j_seen, sym_k_seen, sym_false_start} <= m;
      @(posedge clk_sys);
      {sym_j_seen, sym_k_seen, sym_false_start} <= 3'b000;
      #1;
   endtask
   initial
   begin
      int n;
      logic [15:0] d;
      void'($urandom(84315));
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(`SSCR_ADDR_FIRST, 16'h0000, `SSCR_RESP_OKAY);
      rd(`SSCR_ADDR_SECOND, 16'h0000, `SSCR_RESP_OKAY);
      rd(12'h100, 16'h0000, `SSCR_RESP_SLVERR);
      wr(12'h100, 16'hffff, `SSCR_RESP_SLVERR);
      repeat (6)
      begin
         d = 16'($urandom);
         wr(`SSCR_ADDR_SECOND, d, `SSCR_RESP_OKAY);
         rd(`SSCR_ADDR_SECOND, d & `SSCR_SECOND_WMASK, `SSCR_RESP_OKAY,
            $urandom_range(3));
      end
      pls(3'b100);
      chk("rx_valid", 34'(rx_valid), 34'h0);
      pls(3'b010);
      chk("rx_valid", 34'(rx_valid), 34'h1);
      wr(`SSCR_ADDR_SECOND, 16'h0020, `SSCR_RESP_OKAY);
      wr(`SSCR_ADDR_FIRST, 16'h0003, `SSCR_RESP_OKAY);
      chk("early", 34'(early_rx_valid_enable), 34'h0);
      wr(`SSCR_ADDR_FIRST, 16'h8003, `SSCR_RESP_OKAY);
      for (n = 0; n < 20 && internal_reset !== 1'b1; n++) @(posedge clk_sys);
      n = 0;
      do
      begin
         n++;
         @(posedge clk_sys);
      end
      while (internal_reset === 1'b1 && n < 9);
      chk("pulse", 34'(n), 34'(`SSCR_RST_PULSE_CYC));
      repeat (3) @(posedge clk_sys);
      #1;
      chk("cfg", 34'({early_rx_valid_enable, irq_or_powerdown_oe, phy_special_control[0]}),
          34'h7);
      rd(`SSCR_ADDR_FIRST, 16'h0003, `SSCR_RESP_OKAY, 2);
      wr(`SSCR_ADDR_FIRST, 16'h0000, `SSCR_RESP_OKAY);
      #1;
      chk("irq_oe", 34'(irq_or_powerdown_oe), 34'h1);
      @(posedge clk_sys);
      partner_forced_100 <= 1'b1;
      std_full_duplex <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("full_duplex", 34'(link_full_duplex), 34'h1);
      pls(3'b001);
      chk("rx_error", 34'(rx_error), 34'h1);
      repeat (8)
      begin
         @(posedge clk_sys);
         partner_forced_100 <= 1'b0;
         std_full_duplex <= 1'($urandom);
         @(posedge clk_sys);
         #1;
         chk("std_duplex", 34'(link_full_duplex), 34'(std_full_duplex));
      end
      wr(`SSCR_ADDR_FIRST, 16'h0020, `SSCR_RESP_OKAY);
      wr(`SSCR_ADDR_SECOND, 16'h0000, `SSCR_RESP_OKAY);
      rd(`SSCR_ADDR_SECOND, 16'h0040, `SSCR_RESP_OKAY);
      wr(`SSCR_ADDR_FIRST, 16'h8020, `SSCR_RESP_OKAY);
      partner_forced_100 <= 1'b1;
      std_full_duplex <= 1'b0;
      repeat (10) @(posedge clk_sys);
      #1;
      chk("relatch", 34'({fast_pd_link_up, early_rx_valid_enable, irq_or_powerdown_oe,
          link_full_duplex}), 34'h8);
      rd(`SSCR_ADDR_STATUS, 16'h0002, `SSCR_RESP_OKAY);
      // Reset again mid-run: latched config and interrupt-enable strap must clear
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      chk("reset", 34'({fast_pd_link_up, irq_or_powerdown_oe, internal_reset,
          phy_special_control}), 34'h0);
      rd(`SSCR_ADDR_FIRST, 16'h0000, `SSCR_RESP_OKAY);
      rd(`SSCR_ADDR_SECOND, 16'h0000, `SSCR_RESP_OKAY);
      end_of_test;
   end
endmodule
`default_nettype wire
